// [drop_reason_classifier.sv]
// Maps a drop verdict from the forwarding engine onto a reason code
`timescale 1ns/100ps
module drop_reason_classifier
(
  input  wire drop_status_pkg::drop_cond_t    cond,
  output drop_status_pkg::drop_verdict_t verdict
);

  logic unknown_da;

  assign unknown_da = !cond.da_found;

  always_comb
  begin
    verdict = '{known: 1'b1, reason: drop_status_pkg::RSN_VID_ALL_ONES};
    if (cond.vid == drop_status_pkg::VID_ALL_ONES)
    begin
      verdict.reason = drop_status_pkg::RSN_VID_ALL_ONES;
    end
    else if (cond.tagged_only_admission && cond.frame_untagged)
    begin
      verdict.reason = drop_status_pkg::RSN_TAGGED_ONLY;
    end
    else if (unknown_da && !cond.src_forwarding)
    begin
      verdict.reason = drop_status_pkg::RSN_UNK_SRC_NOFWD;
    end
    else if (unknown_da && cond.membership_check && !cond.admit_non_member && !cond.src_member)
    begin
      verdict.reason = drop_status_pkg::RSN_UNK_SRC_NONMEM;
    end
    else if (unknown_da && cond.da_broadcast && cond.bcast_throttled)
    begin
      verdict.reason = drop_status_pkg::RSN_BCAST_THROTTLE;
    end
    else if (unknown_da && !cond.da_multicast && !cond.da_broadcast && cond.drop_unknown_unicast)
    begin
      verdict.reason = drop_status_pkg::RSN_UNK_UNICAST;
    end
    else if (unknown_da && cond.da_multicast && !cond.da_broadcast && cond.filter_unknown_multicast)
    begin
      verdict.reason = drop_status_pkg::RSN_UNK_MULTICAST;
    end
    else if (cond.da_found && !cond.src_forwarding)
    begin
      verdict.reason = drop_status_pkg::RSN_SRC_NOT_FWD;
    end
    else if (cond.da_found && !cond.dst_forwarding)
    begin
      verdict.reason = drop_status_pkg::RSN_DST_NOT_FWD;
    end
    else if (cond.da_found && cond.same_port)
    begin
      verdict.reason = drop_status_pkg::RSN_SAME_PORT;
    end
    else if (cond.da_found && cond.entry_filter)
    begin
      verdict.reason = drop_status_pkg::RSN_FILTERED_ADDR;
    end
    else if (cond.da_found && cond.membership_check && !cond.dst_member)
    begin
      verdict.reason = drop_status_pkg::RSN_DST_NONMEM;
    end
    else if (cond.da_found && cond.membership_check && !cond.admit_non_member && !cond.src_member)
    begin
      verdict.reason = drop_status_pkg::RSN_SRC_NONMEM;
    end
    else
    begin
      // No documented cause: never invent a reserved code
      verdict.known = 1'b0;
    end
  end

endmodule

// [drop_status_pkg.sv]
// Constants, field layouts and carrier types for the drop event status block
//
// Functional notes
// - Two record slots, A and B; B fills only when A is full.
// - Bit 0 pending set on any drop.
// - Bit 1 flags slot A; bits 7:2 valid.
// - Bit 8 flags slot B; bits 14:9 valid.
// - Slot B reason code in bits 14:11.
// - Slot A reason bits 7:4, same codes.
// - Slot B port bits 10:9; 11 never.
// - Slot A port bits 3:2, same encoding.
// - Reason 0000: tagged-only, untagged or priority frame.
// - Reason 0001: unknown, member check, source outside.
// - Found: 0010 source, 0011 destination not forwarding.
// - Found, member check: 0100 destination, 0101 source.
// - 0110 unknown unicast, 0111 unknown multicast filtered.
// - Reason 1000: broadcast over throttling limit.
// - Reason 1001: unknown, source not forwarding.
// - Found: 1010 same port, 1011 filter flag.
// - Reason 1110: frame with VLAN ID FFFh.
// - Mask suppresses interrupt, never status capture.
// - Single mask bit, 1 after reset.
package drop_status_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] DROP_EVENT_MASK_IDX   = 16'h1880;
  localparam logic [15:0] DROP_EVENT_STATUS_IDX = 16'h1881;
  localparam logic [17:0] DROP_EVENT_MASK_ADDR   = {DROP_EVENT_MASK_IDX, 2'b00};
  localparam logic [17:0] DROP_EVENT_STATUS_ADDR = {DROP_EVENT_STATUS_IDX, 2'b00};
  localparam int          ADDR_DECODE_W          = 18;

  localparam logic        MASK_RESET      = 1'b1;
  localparam logic [1:0]  PORT_CODE_MAX   = 2'h2;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'b0;
  localparam logic [11:0] VID_ALL_ONES    = 12'hFFF;

  // Drop reason codes
  localparam logic [3:0] RSN_TAGGED_ONLY    = 4'h0;
  localparam logic [3:0] RSN_UNK_SRC_NONMEM = 4'h1;
  localparam logic [3:0] RSN_SRC_NOT_FWD    = 4'h2;
  localparam logic [3:0] RSN_DST_NOT_FWD    = 4'h3;
  localparam logic [3:0] RSN_DST_NONMEM     = 4'h4;
  localparam logic [3:0] RSN_SRC_NONMEM     = 4'h5;
  localparam logic [3:0] RSN_UNK_UNICAST    = 4'h6;
  localparam logic [3:0] RSN_UNK_MULTICAST  = 4'h7;
  localparam logic [3:0] RSN_BCAST_THROTTLE = 4'h8;
  localparam logic [3:0] RSN_UNK_SRC_NOFWD  = 4'h9;
  localparam logic [3:0] RSN_SAME_PORT      = 4'hA;
  localparam logic [3:0] RSN_FILTERED_ADDR  = 4'hB;
  localparam logic [3:0] RSN_VID_ALL_ONES   = 4'hE;

  // Status word layout, bit 31 first
  typedef struct packed {
    logic [16:0] reserved;
    logic [3:0]  b_reason;
    logic [1:0]  b_port;
    logic        b_valid;
    logic [3:0]  a_reason;
    logic [1:0]  a_port;
    logic        a_valid;
    logic        pending;
  } drop_status_t;

  localparam drop_status_t STATUS_RESET = '0;

  // Forwarding engine verdict for one dropped frame
  typedef struct packed {
    logic        tagged_only_admission;
    logic        frame_untagged;
    logic [11:0] vid;
    logic        da_found;
    logic        da_broadcast;
    logic        da_multicast;
    logic        membership_check;
    logic        admit_non_member;
    logic        src_member;
    logic        dst_member;
    logic        src_forwarding;
    logic        dst_forwarding;
    logic        same_port;
    logic        entry_filter;
    logic        drop_unknown_unicast;
    logic        filter_unknown_multicast;
    logic        bcast_throttled;
  } drop_cond_t;

  typedef struct packed {
    logic       known;
    logic [3:0] reason;
  } drop_verdict_t;

endpackage

// [switch_drop_event_status.sv]
// Drop event status and mask registers behind an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
module switch_drop_event_status
(
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        drop_event,
  input  wire logic [1:0]                  drop_port,
  input  wire drop_status_pkg::drop_cond_t drop_cond,
  output logic                             drop_irq
);

  drop_status_pkg::drop_status_t  status_ff;
  drop_status_pkg::drop_status_t  nxt_status;
  drop_status_pkg::drop_status_t  base_status;
  drop_status_pkg::drop_verdict_t verdict;
  logic                           mask_ff;
  logic                           nxt_mask;
  logic                           wr_pend_ff;
  logic [17:0]                    wr_addr_ff;
  logic [31:0]                    hrdata_ff;
  logic [31:0]                    nxt_hrdata;
  logic                           hreadyout_ff;
  logic                           hresp_ff;
  logic                           drop_irq_ff;
  logic                           addr_phase;
  logic                           rd_status;
  logic                           recordable;

  function automatic logic addr_is(input logic [31:0] a, input logic [17:0] reg_addr);
    addr_is = (a[31:18] == '0) && (a[17:0] == reg_addr);
  endfunction

  drop_reason_classifier drop_reason_classifier_i
  (
    .cond    (drop_cond),
    .verdict (verdict)
  );

  // Valid transfer taken at this edge
  assign addr_phase = hsel && hready && htrans[1];
  assign rd_status  = addr_phase && !hwrite && addr_is(haddr, drop_status_pkg::DROP_EVENT_STATUS_ADDR);
  assign recordable = verdict.known && (drop_port <= drop_status_pkg::PORT_CODE_MAX);

  // Status update: read clear first, then a same-cycle event lands
  always_comb
  begin
    base_status = rd_status ? drop_status_pkg::STATUS_RESET : status_ff;
    nxt_status  = base_status;
    if (drop_event)
    begin
      nxt_status.pending = 1'b1;
      if (recordable && !base_status.a_valid)
      begin
        nxt_status.a_valid  = 1'b1;
        nxt_status.a_port   = drop_port;
        nxt_status.a_reason = verdict.reason;
      end
      else if (recordable && !base_status.b_valid)
      begin
        nxt_status.b_valid  = 1'b1;
        nxt_status.b_port   = drop_port;
        nxt_status.b_reason = verdict.reason;
      end
    end
    nxt_status.reserved = '0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_ff <= drop_status_pkg::STATUS_RESET;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  // Write data phase bookkeeping
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end
    else
    begin
      wr_pend_ff <= addr_phase && hwrite && (haddr[31:18] == '0);
      wr_addr_ff <= haddr[17:0];
    end
  end

  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr_pend_ff && (wr_addr_ff == drop_status_pkg::DROP_EVENT_MASK_ADDR))
    begin
      nxt_mask = hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_ff <= drop_status_pkg::MASK_RESET;
    end
    else
    begin
      mask_ff <= nxt_mask;
    end
  end

  // Read data captured at the address phase edge, zero wait
  always_comb
  begin
    nxt_hrdata = '0;
    if (addr_phase && !hwrite)
    begin
      if (addr_is(haddr, drop_status_pkg::DROP_EVENT_STATUS_ADDR))
      begin
        nxt_hrdata = status_ff;
      end
      else if (addr_is(haddr, drop_status_pkg::DROP_EVENT_MASK_ADDR))
      begin
        nxt_hrdata = {31'h0, nxt_mask};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff    <= '0;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= drop_status_pkg::HRESP_OKAY;
    end
    else
    begin
      hrdata_ff    <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= drop_status_pkg::HRESP_OKAY;
    end
  end

  // Mask gates only the interrupt line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drop_irq_ff <= 1'b0;
    end
    else
    begin
      drop_irq_ff <= nxt_status.pending && !nxt_mask;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;
  assign drop_irq  = drop_irq_ff;

endmodule

// [switch_drop_event_status_chk.sv]
// Port-level checker for the drop event status block
`timescale 1ns/100ps
module switch_drop_event_status_chk
(
  input wire logic                        hclk,
  input wire logic                        hresetn,
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic [2:0]                  hsize,
  input wire logic [31:0]                 hwdata,
  input wire logic                        hready,
  input wire logic [31:0]                 hrdata,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  input wire logic                        drop_event,
  input wire logic [1:0]                  drop_port,
  input wire drop_status_pkg::drop_cond_t drop_cond,
  input wire logic                        drop_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd_st;
  logic wr_mk;
  assign rd_st = hsel && hready && htrans[1] && !hwrite && (haddr == {14'h0000, drop_status_pkg::DROP_EVENT_STATUS_ADDR});
  assign wr_mk = hsel && hready && htrans[1] && hwrite && (haddr == {14'h0000, drop_status_pkg::DROP_EVENT_MASK_ADDR});
  property p_top_zero;
    hrdata[31:15] == 17'h00000;
  endproperty
  property p_a_valid;
    hrdata[1] |-> hrdata[0] && (hrdata[3:2] != 2'h3);
  endproperty
  property p_b_after_a;
    hrdata[8] |-> hrdata[1] && (hrdata[10:9] != 2'h3);
  endproperty
  property p_rsv;
    hrdata[1] |-> !(hrdata[7:4] inside {4'hC, 4'hD, 4'hF});
  endproperty
  property p_rsv_b;
    hrdata[8] |-> !(hrdata[14:11] inside {4'hC, 4'hD, 4'hF});
  endproperty
  property p_irq_pend;
    drop_irq && rd_st |=> hrdata[0];
  endproperty
  property p_evt_seen;
    drop_event ##1 rd_st |=> hrdata[0];
  endproperty
  property p_rd_clear;
    rd_st && !drop_event ##1 !drop_event ##1 rd_st |=> hrdata == 32'h00000000;
  endproperty
  property p_mask_blk;
    wr_mk ##1 hwdata[0] |=> !drop_irq;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("status upper bits not zero");
  a_a_valid: assert property (p_a_valid) else $error("slot A valid without pending or bad port");
  a_b_after_a: assert property (p_b_after_a) else $error("slot B filled before slot A");
  a_rsv: assert property (p_rsv) else $error("reserved reason code reported");
  a_rsv_b: assert property (p_rsv_b) else $error("reserved reason code reported in slot B");
  a_irq_pend: assert property (p_irq_pend) else $error("interrupt without pending flag");
  a_evt_seen: assert property (p_evt_seen) else $error("drop not flagged as pending");
  a_rd_clear: assert property (p_rd_clear) else $error("status not cleared by read");
  a_mask_blk: assert property (p_mask_blk) else $error("mask does not block interrupt");
  c_both: cover property (rd_st ##1 hrdata[8]);
  c_irq: cover property ($rose(drop_irq));
  c_port3: cover property (drop_event && (drop_port == 2'h3));
endmodule

bind switch_drop_event_status switch_drop_event_status_chk switch_drop_event_status_chk_i
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .drop_event, .drop_port, .drop_cond, .drop_irq
);

// [switch_drop_event_status_tb_top.sv]
// Self-checking bench for the drop event status block
`timescale 1ns/100ps
module switch_drop_event_status_tb_top;
  localparam logic [31:0] ADDR_MK = {14'h0000, drop_status_pkg::DROP_EVENT_MASK_ADDR};
  localparam logic [31:0] ADDR_ST = {14'h0000, drop_status_pkg::DROP_EVENT_STATUS_ADDR};
  logic                        hclk       = 1'b0;
  logic                        hresetn    = 1'b0;
  logic                        hsel       = 1'b0;
  logic [31:0]                 haddr      = 32'h00000000;
  logic [1:0]                  htrans     = 2'h0;
  logic                        hwrite     = 1'b0;
  logic [31:0]                 hwdata     = 32'h00000000;
  logic                        drop_event = 1'b0;
  logic [1:0]                  drop_port  = 2'h0;
  drop_status_pkg::drop_cond_t drop_cond  = '0;
  logic [31:0]                 hrdata;
  logic                        hreadyout;
  logic                        hresp;
  logic                        drop_irq;
  logic [31:0]                 rd;
  int                          mismatches = 0;
  int                          n_checks   = 0;

  always #2 hclk = ~hclk;

  switch_drop_event_status switch_drop_event_status_i
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .drop_event(drop_event), .drop_port(drop_port), .drop_cond(drop_cond), .drop_irq(drop_irq)
  );

  task automatic stop_test;
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Verdict that yields reason code r and nothing of higher priority
  function automatic drop_status_pkg::drop_cond_t cnd(input logic [3:0] r);
    drop_status_pkg::drop_cond_t c;
    c.tagged_only_admission = (r == 4'h0);
    c.frame_untagged = (r == 4'h0);
    c.vid = (r == 4'hE) ? 12'hFFF : 12'h001;
    c.da_found = !(r inside {4'h1, 4'h6, 4'h7, 4'h8, 4'h9});
    c.da_broadcast = r inside {4'h1, 4'h8};
    c.da_multicast = (r == 4'h7);
    c.membership_check = r inside {4'h1, 4'h4, 4'h5};
    c.admit_non_member = !(r inside {4'h1, 4'h5});
    c.src_member = !(r inside {4'h1, 4'h5});
    c.dst_member = (r != 4'h4);
    c.src_forwarding = !(r inside {4'h2, 4'h9});
    c.dst_forwarding = (r != 4'h3);
    c.same_port = (r == 4'hA);
    c.entry_filter = (r == 4'hB);
    c.drop_unknown_unicast = (r == 4'h6);
    c.filter_unknown_multicast = (r == 4'h7);
    c.bcast_throttled = (r == 4'h8);
    return c;
  endfunction

  task automatic wait_rdy(output logic [31:0] d);
    @(negedge hclk);
    while (hreadyout !== 1'b1)
      @(negedge hclk);
    d = hrdata;
    chk("hresp", 32'h00000000, {31'h0, hresp});
    @(posedge hclk);
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= drop_status_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy(d);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
  endtask

  task automatic drop(input logic [1:0] p, input logic [3:0] r);
    drop_event <= 1'b1;
    drop_port  <= p;
    drop_cond  <= cnd(r);
    @(posedge hclk);
    drop_event <= 1'b0;
  endtask

  task automatic irq_is(input logic e);
    @(negedge hclk);
    chk("drop_irq", {31'h0, e}, {31'h0, drop_irq});
    @(posedge hclk);
  endtask

  task automatic t_reset;
    xfer(ADDR_ST, 1'b0, 32'h0, rd);
    chk("status", 32'h00000000, rd);
    xfer(ADDR_MK, 1'b0, 32'h0, rd);
    chk("mask", 32'h00000001, rd);
    irq_is(1'b0);
  endtask

  task automatic t_reasons;
    logic [3:0] codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE};
    foreach (codes[i])
    begin
      drop(2'(i % 3), codes[i]);
      xfer(ADDR_ST, 1'b0, 32'h0, rd);
      chk("slot_a", {24'h0, codes[i], 2'(i % 3), 2'h3}, rd);
    end
  endtask

  task automatic t_slots;
    drop(2'h0, 4'h3);
    @(posedge hclk);
    drop(2'h1, 4'hE);
    @(posedge hclk);
    drop(2'h2, 4'hA);
    xfer(ADDR_ST, 1'b0, 32'h0, rd);
    chk("two_slots", {17'h0, 4'hE, 2'h1, 1'b1, 4'h3, 2'h0, 2'h3}, rd);
    xfer(ADDR_ST, 1'b0, 32'h0, rd);
    chk("cleared", 32'h00000000, rd);
    drop(2'h3, 4'h2);
    xfer(ADDR_ST, 1'b0, 32'h0, rd);
    chk("port3", 32'h00000001, rd);
    drop(2'h1, 4'hC);
    xfer(ADDR_ST, 1'b0, 32'h0, rd);
    chk("no_cause", 32'h00000001, rd);
    fork
      drop(2'h2, 4'h9);
      xfer(ADDR_ST, 1'b0, 32'h0, rd);
    join
    chk("clear_vs_event_old", 32'h00000000, rd);
    xfer(ADDR_ST, 1'b0, 32'h0, rd);
    chk("clear_vs_event_new", 32'h0000009B, rd);
  endtask

  task automatic t_mask;
    drop(2'h2, 4'h0);
    irq_is(1'b0);
    xfer(ADDR_MK, 1'b1, 32'h0, rd);
    irq_is(1'b1);
    xfer(ADDR_ST, 1'b0, 32'h0, rd);
    chk("masked_capture", 32'h0000000B, rd);
    irq_is(1'b0);
    xfer(ADDR_MK, 1'b1, 32'hFFFFFFFF, rd);
    xfer(32'h00006208, 1'b1, 32'hFFFFFFFF, rd);
    xfer(32'h00006208, 1'b0, 32'h0, rd);
    chk("unmapped", 32'h00000000, rd);
    xfer(ADDR_MK, 1'b0, 32'h0, rd);
    chk("mask_back", 32'h00000001, rd);
  endtask

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_reasons;
    t_slots;
    t_mask;
    stop_test;
  end

  initial
  begin
    repeat (3000) @(posedge hclk);
    mismatches++;
    stop_test;
  end
endmodule
